// >>> logic/cje_pkg.sv
`default_nettype none
package cje_pkg;
    // bus and register geometry
    localparam int          DATA_W        = 32;
    localparam int          WORD_W        = 16;
    localparam int          OFF_W         = 10;
    localparam int          DEC_W         = 5;
    localparam logic [4:0]  OFS_CTRL      = 5'h00;
    localparam logic [4:0]  OFS_INSTR     = 5'h04;
    localparam logic [4:0]  OFS_PC        = 5'h08;
    localparam logic [4:0]  OFS_SR        = 5'h0C;
    localparam logic [4:0]  OFS_STATUS    = 5'h10;
    localparam logic [4:0]  OFS_TAKEN_CNT = 5'h14;
    localparam logic [4:0]  OFS_FALL_CNT  = 5'h18;
    // control and status fields
    localparam int          CTRL_GO_BIT   = 0;
    localparam int          CTRL_CLR_BIT  = 1;
    localparam int          ST_BUSY_BIT   = 0;
    localparam int          ST_TAKEN_BIT  = 1;
    localparam int          ST_DONE_BIT   = 2;
    localparam int          ST_ILL_BIT    = 3;
    // status word flag positions
    localparam int          SR_C_BIT      = 0;
    localparam int          SR_Z_BIT      = 1;
    localparam int          SR_N_BIT      = 2;
    localparam int          SR_V_BIT      = 8;
    // jump instruction layout
    localparam logic [2:0]  JMP_OPC       = 3'h1;
    localparam logic [2:0]  COND_EQUAL    = 3'h1;
    localparam logic [2:0]  COND_CARRY    = 3'h3;
    localparam logic [2:0]  COND_SGE      = 3'h5;
    localparam logic [15:0] PC_STEP       = 16'h0002;
    // reset values
    localparam logic [15:0] RST_WORD      = 16'h0000;
    localparam logic [31:0] RST_BUS       = 32'h0000_0000;
    typedef enum logic [1:0] {CJE_IDLE, CJE_EVAL} cje_state_t;
endpackage
`default_nettype wire

// >>> logic/cje_eval_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cje_eval_if;
    logic [15:0] instr;
    logic [15:0] sr;
    logic [15:0] pc;
    logic [15:0] target;
    logic [15:0] next_seq;
    logic        take;
    logic        known;
    modport cond (input instr, input sr, output take, output known);
    modport tgt  (input instr, input pc, output target, output next_seq);
    modport core (output instr, output sr, output pc,
                  input target, input next_seq, input take, input known);
endinterface
`default_nettype wire

// >>> logic/cje_cond.sv
`timescale 1ns/1ns
`default_nettype none
module cje_cond
(
    cje_eval_if.cond e
);
    import cje_pkg::*;

    wire       is_jump;
    wire [2:0] cond;
    wire       hit_carry;
    wire       hit_zero;
    wire       hit_sge;
    wire       cf;
    wire       zf;
    wire       nf;
    wire       vf;

    // class decode; one code serves both assembler spellings
    assign is_jump   = (e.instr[15:13] == JMP_OPC);
    assign cond      = e.instr[12:10];
    assign hit_carry = is_jump && (cond == COND_CARRY);
    assign hit_zero  = is_jump && (cond == COND_EQUAL);
    assign hit_sge   = is_jump && (cond == COND_SGE);

    // flag taps, read only: nothing here writes the status word
    assign cf = e.sr[SR_C_BIT];
    assign zf = e.sr[SR_Z_BIT];
    assign nf = e.sr[SR_N_BIT];
    assign vf = e.sr[SR_V_BIT];

    // branch decision; for carry and zero a clear flag falls through, signed >= takes on N equal to V
    assign e.take  = (hit_carry & cf)
                   | (hit_zero & zf)
                   | (hit_sge & ~(nf ^ vf));
    assign e.known = hit_carry | hit_zero | hit_sge;
endmodule
`default_nettype wire

// >>> logic/cje_target.sv
`timescale 1ns/1ns
`default_nettype none
module cje_target
#(
    parameter int OFFSET_W = 10
)
(
    cje_eval_if.tgt e
);
    import cje_pkg::*;

    wire [15:0] off_ext;
    wire [15:0] off_dbl;

    // signed offset from the low bits, then doubled to a byte distance
    assign off_ext = {{(16 - OFFSET_W){e.instr[OFFSET_W - 1]}},
                      e.instr[OFFSET_W - 1:0]};
    assign off_dbl = {off_ext[14:0], 1'b0};

    // base is the word after the jump, so offset zero is sequential
    assign e.next_seq = e.pc + PC_STEP;
    assign e.target   = e.next_seq + off_dbl;
endmodule
`default_nettype wire

// >>> logic/cje_top.sv
`timescale 1ns/1ns
`default_nettype none
module cje_top
#(
    parameter int CNT_W    = 16,
    parameter int OFFSET_W = 10
)
(
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [cje_pkg::DATA_W-1:0] hwdata,
    input  wire logic                      hready,
    output var  logic [cje_pkg::DATA_W-1:0] hrdata,
    output var  logic                      hreadyout,
    output var  logic                      hresp,
    output var  logic [15:0]               pc_value,
    output var  logic                      last_taken,
    output var  logic                      busy
);
    import cje_pkg::*;

    // one bundle carries the stored words to both evaluator halves
    cje_eval_if e ();

    // condition test, purely combinational
    cje_cond u_cond
    (
        .e (e.cond)
    );

    // target and fall-through address, also combinational
    cje_target #(.OFFSET_W(OFFSET_W)) u_target
    (
        .e (e.tgt)
    );

    // architectural words, result flags and outcome counters
    cje_state_t           state_r;
    cje_state_t           state_nxt;
    logic [15:0]          instr_r;
    logic [15:0]          pc_r;
    logic [15:0]          pc_nxt;
    logic [15:0]          sr_r;
    logic                 taken_r;
    logic                 done_r;
    logic                 ill_r;
    logic                 busy_r;
    logic [CNT_W-1:0]     tcnt_r;
    logic [CNT_W-1:0]     fcnt_r;
    // bus side bookkeeping
    logic [DATA_W-1:0]    hrdata_r;
    logic                 hreadyout_r;
    logic                 wr_pend_r;
    logic                 rd_pend_r;
    logic [DEC_W-1:0]     addr_r;

    // register decode, shared by the read mux and the write strobes
    function automatic logic hit(input logic [DEC_W-1:0] a,
                                 input logic [DEC_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // decode, strobe and selection nets
    wire                  phase_ok;
    wire                  wr_take;
    wire                  rd_take;
    wire                  wr_ctrl;
    wire                  wr_instr;
    wire                  wr_pc;
    wire                  wr_sr;
    wire                  wr_status;
    wire                  go;
    wire                  clr_stats;
    wire                  clr_done;
    wire                  eval_now;
    wire                  commit_take;
    wire                  commit_fall;
    wire [DATA_W-1:0]     status_word;
    wire [DATA_W-1:0]     rd_mux;
    wire                  word_aligned;
    // read views of each register, widened to the bus word
    wire [DATA_W-1:0]     rd_instr;
    wire [DATA_W-1:0]     rd_pc;
    wire [DATA_W-1:0]     rd_sr;
    wire [DATA_W-1:0]     rd_tcnt;
    wire [DATA_W-1:0]     rd_fcnt;

    // address phase accepted when selected, active and the bus is ready
    assign phase_ok     = hsel && htrans[1] && hready;
    assign word_aligned = (haddr[1:0] == 2'h0);
    assign wr_take      = phase_ok && hwrite && word_aligned;
    assign rd_take      = phase_ok && !hwrite;

    // write strobes in the data phase, decoded from the held address
    assign wr_ctrl   = wr_pend_r && hit(addr_r, OFS_CTRL);
    assign wr_instr  = wr_pend_r && hit(addr_r, OFS_INSTR);
    assign wr_pc     = wr_pend_r && hit(addr_r, OFS_PC);
    assign wr_sr     = wr_pend_r && hit(addr_r, OFS_SR);
    assign wr_status = wr_pend_r && hit(addr_r, OFS_STATUS);

    // self-clearing control bits; go is ignored while an evaluation runs
    assign go        = wr_ctrl && hwdata[CTRL_GO_BIT] && (state_r == CJE_IDLE);
    assign clr_stats = wr_ctrl && hwdata[CTRL_CLR_BIT];
    assign clr_done  = wr_status && hwdata[ST_DONE_BIT];

    // evaluation cycle outcome
    assign eval_now    = (state_r == CJE_EVAL);
    assign commit_take = eval_now && e.known && e.take;
    assign commit_fall = eval_now && e.known && !e.take;

    // evaluator sees the stored words only
    assign e.instr = instr_r;
    assign e.sr    = sr_r;
    assign e.pc    = pc_r;

    // upper bits read zero, so software may mask nothing
    assign rd_instr = {16'h0000, instr_r};
    assign rd_pc    = {16'h0000, pc_r};
    assign rd_sr    = {16'h0000, sr_r};
    assign rd_tcnt  = {{(DATA_W - CNT_W){1'b0}}, tcnt_r};
    assign rd_fcnt  = {{(DATA_W - CNT_W){1'b0}}, fcnt_r};

    // status word and read selection; unmapped offsets read zero
    assign status_word = {{(DATA_W - 4){1'b0}}, ill_r, done_r, taken_r,
                          busy_r};
    assign rd_mux = hit(addr_r, OFS_CTRL)      ? RST_BUS
                  : hit(addr_r, OFS_INSTR)     ? rd_instr
                  : hit(addr_r, OFS_PC)        ? rd_pc
                  : hit(addr_r, OFS_SR)        ? rd_sr
                  : hit(addr_r, OFS_STATUS)    ? status_word
                  : hit(addr_r, OFS_TAKEN_CNT) ? rd_tcnt
                  : hit(addr_r, OFS_FALL_CNT)  ? rd_fcnt
                  : RST_BUS;

    // sequencer: one idle-to-eval hop per go
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            CJE_IDLE:
            begin
                if (go)
                    state_nxt = CJE_EVAL;
            end
            CJE_EVAL:
            begin
                state_nxt = CJE_IDLE;
            end
            default:
            begin
                state_nxt = CJE_IDLE;
            end
        endcase
    end

    // counter update; the evaluation wins over a software write
    assign pc_nxt = commit_take ? e.target
                  : commit_fall ? e.next_seq
                  : wr_pc       ? hwdata[15:0]
                  : pc_r;

    // sequencer state
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            state_r <= CJE_IDLE;
        else
            state_r <= state_nxt;
    end

    // counter register; takes both outcomes of an evaluation
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            pc_r <= RST_WORD;
        else
            pc_r <= pc_nxt;
    end

    // instruction word, software only
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            instr_r <= RST_WORD;
        else if (wr_instr)
            instr_r <= hwdata[15:0];
    end

    // status word: only software writes it, evaluation never does
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            sr_r <= RST_WORD;
        else if (wr_sr)
            sr_r <= hwdata[15:0];
    end

    // result flags of the last evaluation
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            taken_r <= 1'b0;
        else if (eval_now)
            taken_r <= commit_take;
    end

    // an unhandled word is flagged rather than trapped
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ill_r <= 1'b0;
        else if (eval_now)
            ill_r <= !e.known;
    end

    // done is sticky; a completion in the clearing cycle survives
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            done_r <= 1'b0;
        else if (eval_now)
            done_r <= 1'b1;
        else if (clr_done)
            done_r <= 1'b0;
    end

    // busy comes from the next state, so it marks the eval cycle itself
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            busy_r <= 1'b0;
        else
            busy_r <= (state_nxt == CJE_EVAL);
    end

    // outcome counters; they wrap, and a count beats a clear
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            tcnt_r <= '0;
        else if (commit_take)
            tcnt_r <= tcnt_r + 1'b1;
        else if (clr_stats)
            tcnt_r <= '0;
    end

    // fall-through count mirrors the taken count
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            fcnt_r <= '0;
        else if (commit_fall)
            fcnt_r <= fcnt_r + 1'b1;
        else if (clr_stats)
            fcnt_r <= '0;
    end

    // bus phase tracking; misaligned writes are dropped silently
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            wr_pend_r <= 1'b0;
        else if (hreadyout_r)
            wr_pend_r <= wr_take;
        else
            wr_pend_r <= 1'b0;
    end

    // a read in its wait state never opens a second data phase
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rd_pend_r <= 1'b0;
        else if (hreadyout_r)
            rd_pend_r <= rd_take;
        else
            rd_pend_r <= 1'b0;
    end

    // address held for the data phase; idle cycles keep the old one
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            addr_r <= '0;
        else if (hreadyout_r && phase_ok)
            addr_r <= haddr[DEC_W-1:0];
    end

    // reads take one wait state, so a preceding write is already stored
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            hreadyout_r <= 1'b1;
        else if (rd_take && hreadyout_r)
            hreadyout_r <= 1'b0;
        else
            hreadyout_r <= 1'b1;
    end

    // read data loads in the wait state and then holds
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            hrdata_r <= RST_BUS;
        else if (rd_pend_r)
            hrdata_r <= rd_mux;
    end

    // outputs straight from flops; response is always okay
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            hresp <= 1'b0;
        else
            hresp <= 1'b0;
    end

    // port aliases of the output flops
    assign hrdata     = hrdata_r;
    assign hreadyout  = hreadyout_r;
    assign pc_value   = pc_r;
    assign last_taken = taken_r;
    assign busy       = busy_r;
endmodule
`default_nettype wire

// >>> testbench/cje_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module cje_top_properties
#(
    parameter int CNT_W    = 16,
    parameter int OFFSET_W = 10
)
(
    input wire logic                        core_clk,
    input wire logic                        rst,
    input wire logic                        hsel,
    input wire logic [31:0]                 haddr,
    input wire logic [1:0]                  htrans,
    input wire logic                        hwrite,
    input wire logic [2:0]                  hsize,
    input wire logic [cje_pkg::DATA_W-1:0]  hwdata,
    input wire logic                        hready,
    input wire logic [cje_pkg::DATA_W-1:0]  hrdata,
    input wire logic                        hreadyout,
    input wire logic                        hresp,
    input wire logic [15:0]                 pc_value,
    input wire logic                        last_taken,
    input wire logic                        busy
);
    import cje_pkg::*;
    logic        acc;
    logic        wr_dp;
    logic        legal;
    logic [2:0]  cond;
    logic [15:0] disp;
    logic        ap_vld_r;
    logic        ap_wr_r;
    logic [4:0]  ap_adr_r;
    logic [15:0] instr_m_r;
    logic [15:0] sr_m_r;
    // shadow decode, so the checks need no view inside the block
    assign acc   = hsel & htrans[1] & hready;
    assign wr_dp = ap_vld_r & ap_wr_r & hready;
    assign cond  = instr_m_r[12:10];
    assign legal = (instr_m_r[15:13] == JMP_OPC) && (cond == COND_EQUAL
                   || cond == COND_CARRY || cond == COND_SGE);
    assign disp  = {{5{instr_m_r[9]}}, instr_m_r[9:0], 1'b0};
    // track bus writes of the jump word and the flag word
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ap_vld_r  <= 1'b0;
            ap_wr_r   <= 1'b0;
            ap_adr_r  <= 5'h00;
            instr_m_r <= 16'h0000;
            sr_m_r    <= 16'h0000;
        end
        else if (hready)
        begin
            ap_vld_r <= acc;
            ap_wr_r  <= hwrite;
            ap_adr_r <= haddr[4:0];
            if (wr_dp && ap_adr_r == OFS_INSTR)
                instr_m_r <= hwdata[15:0];
            if (wr_dp && ap_adr_r == OFS_SR)
                sr_m_r <= hwdata[15:0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_busy_single: assert property (busy |=> !busy)
        else $error("busy held longer than one cycle");
    chk_go_starts: assert property (wr_dp && ap_adr_r == OFS_CTRL
        && hwdata[0] && !busy |=> busy) else $error("go did not start");
    chk_carry_test: assert property (
        busy && legal && cond == COND_CARRY |=> last_taken == sr_m_r[0])
        else $error("carry decision wrong");
    chk_zero_test: assert property (
        busy && legal && cond == COND_EQUAL |=> last_taken == sr_m_r[1])
        else $error("zero decision wrong");
    chk_signed_ge: assert property (busy && legal && cond == COND_SGE
        |=> last_taken == !(sr_m_r[2] ^ sr_m_r[8]))
        else $error("signed decision wrong");
    chk_taken_target: assert property (busy && legal
        |=> !last_taken || pc_value == $past(pc_value) + 16'h0002 + disp)
        else $error("branch target wrong");
    chk_fall_next: assert property (busy && legal
        |=> last_taken || pc_value == $past(pc_value) + 16'h0002)
        else $error("fall through address wrong");
    chk_flags_kept: assert property (acc && !hwrite && haddr[4:0] == OFS_SR
        |=> ##1 hrdata[15:0] == sr_m_r) else $error("flag word changed");
    chk_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
endmodule
bind cje_top cje_top_properties #(.CNT_W(CNT_W), .OFFSET_W(OFFSET_W)) u_props
(
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pc_value(pc_value), .last_taken(last_taken), .busy(busy)
);
`default_nettype wire

// >>> testbench/conditional_jump_eval_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) \
    begin failures++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module conditional_jump_eval_tb;
    import cje_pkg::*;
    logic        core_clk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [15:0] pc_value;
    logic        last_taken;
    logic        busy;
    logic [31:0] rd;
    int          failures = 0;
    int          num_checks = 0;
    int          cycles = 0;
    // one row per case: condition, flags, offset, expected decision
    logic [2:0]  cnd_t [8] = '{COND_CARRY, COND_CARRY, COND_EQUAL,
        COND_EQUAL, COND_SGE, COND_SGE, COND_SGE, COND_SGE};
    logic [15:0] sr_t [8] = '{16'h0001, 16'h0002, 16'h0002, 16'h0001,
        16'h0104, 16'h0000, 16'h0004, 16'h0100};
    logic [9:0]  off_t [8] = '{10'h3FF, 10'h155, 10'h200, 10'h001,
        10'h1FF, 10'h000, 10'h2AA, 10'h0F0};
    logic        tk_t [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

    cje_top uut
    (
        .core_clk   (core_clk),
        .rst        (rst),
        .hsel       (hsel),
        .haddr      (haddr),
        .htrans     (htrans),
        .hwrite     (hwrite),
        .hsize      (hsize),
        .hwdata     (hwdata),
        .hready     (hreadyout),
        .hrdata     (hrdata),
        .hreadyout  (hreadyout),
        .hresp      (hresp),
        .pc_value   (pc_value),
        .last_taken (last_taken),
        .busy       (busy)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic print_verdict();
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ready and read data taken at the rising edge, before the
    // design's non-blocking updates of that edge land
    task automatic wait_ready();
        @(posedge core_clk);
        while (hreadyout !== 1'b1)
            @(posedge core_clk);
        rd = hrdata;
    endtask

    // one single word transfer: address phase, then data phase
    task automatic bus_xfer(input logic wr, input logic [4:0] a,
                            input logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= {27'h0, a};
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask

    // hang guard, far above the two hundred or so cycles needed
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            failures++;
            print_verdict();
        end
    end

    initial
    begin
        logic [15:0] pc0;
        logic [15:0] ex_pc;
        logic [15:0] ins;
        rst = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        bus_xfer(1'b0, OFS_PC, 32'h0);
        `CHECK("pc reset", RST_BUS, rd)
        `CHECK("resp okay", 1'b0, hresp)
        `CHECK("busy idle", 1'b0, busy)
        bus_xfer(1'b0, 5'h1C, 32'h0);
        `CHECK("unmapped", RST_BUS, rd)
        for (int i = 0; i < 8; i++)
        begin
            pc0 = 16'h1F00 + 16'(i) * 16'h1000;
            ins = {JMP_OPC, cnd_t[i], off_t[i]};
            ex_pc = pc0 + PC_STEP
                + (tk_t[i] ? {{5{off_t[i][9]}}, off_t[i], 1'b0} : 16'h0000);
            bus_xfer(1'b1, OFS_SR, {16'h0, sr_t[i]});
            bus_xfer(1'b1, OFS_INSTR, {16'h0, ins});
            bus_xfer(1'b1, OFS_PC, {16'h0, pc0});
            bus_xfer(1'b1, OFS_CTRL, 32'h0000_0001);
            bus_xfer(1'b0, OFS_PC, 32'h0);
            `CHECK("pc", {16'h0, ex_pc}, rd)
            `CHECK("pc port", ex_pc, pc_value)
            `CHECK("taken", tk_t[i], last_taken)
            bus_xfer(1'b0, OFS_STATUS, 32'h0);
            `CHECK("status", {28'h0, 2'b01, tk_t[i], 1'b0}, rd)
            bus_xfer(1'b0, OFS_SR, 32'h0);
            `CHECK("flags", {16'h0, sr_t[i]}, rd)
            bus_xfer(1'b1, OFS_STATUS, 32'h0000_0004);
        end
        // word outside the three handled jumps leaves the counter alone
        bus_xfer(1'b1, OFS_INSTR, 32'h0000_2000);
        bus_xfer(1'b1, OFS_CTRL, 32'h0000_0001);
        bus_xfer(1'b0, OFS_STATUS, 32'h0);
        `CHECK("illegal status", 32'h0000_000C, rd)
        bus_xfer(1'b0, OFS_PC, 32'h0);
        `CHECK("illegal pc", {16'h0, ex_pc}, rd)
        bus_xfer(1'b0, OFS_TAKEN_CNT, 32'h0);
        `CHECK("taken count", 32'h0000_0004, rd)
        bus_xfer(1'b0, OFS_FALL_CNT, 32'h0);
        `CHECK("fall count", 32'h0000_0004, rd)
        // a misaligned write is dropped, the counter keeps its value
        bus_xfer(1'b1, 5'h09, 32'h0000_1234);
        bus_xfer(1'b0, OFS_PC, 32'h0);
        `CHECK("misaligned pc", {16'h0, ex_pc}, rd)
        // the clear bit empties both outcome counters
        bus_xfer(1'b1, OFS_CTRL, 32'h0000_0002);
        bus_xfer(1'b0, OFS_TAKEN_CNT, 32'h0);
        `CHECK("taken cleared", RST_BUS, rd)
        bus_xfer(1'b0, OFS_FALL_CNT, 32'h0);
        `CHECK("fall cleared", RST_BUS, rd)
        print_verdict();
    end
endmodule
`default_nettype wire
